// ### logic/afts_pkg.sv
// shared types and constants of the amplifier fault and thermal supervisor
package afts_pkg;

  // ****************************************************************
  // constants
  // ****************************************************************
  localparam int unsigned AFTS_CNT_W      = 9;
  localparam int unsigned AFTS_TOL_W      = 4;
  localparam int unsigned AFTS_TEMP_W     = 7;
  localparam int unsigned AFTS_ATT_W      = 6;
  // attenuation counts in 0.5 dB steps, 24 steps is -12 dB
  localparam logic [5:0]  AFTS_ATT_MAX    = 6'h18;
  localparam logic [5:0]  AFTS_ATT_RST    = 6'h00;
  localparam logic        AFTS_EN_RST     = 1'b0;
  localparam logic [8:0]  AFTS_CNT_RST    = 9'h000;
  localparam logic [7:0]  AFTS_DUR_RST    = 8'h00;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    AFTS_FMT_I2S,
    AFTS_FMT_LJ,
    AFTS_FMT_TDM
  } afts_fmt_e;

  typedef struct packed {
    logic clk_err;
    logic clk_recover;
    logic speaker_guard_error_irq;
    logic cutoff_begin;
    logic cutoff_end;
    logic warn_low_begin_irq;
    logic warn_low_end_irq;
    logic warn_high_begin_irq;
    logic warn_high_end_irq;
    logic heat_fold_begin_irq;
    logic heat_fold_end_irq;
  } afts_irq_s;

  typedef struct packed {
    logic [6:0] temp_warn_low_threshold;
    logic [6:0] temp_warn_high_threshold;
    logic [5:0] temp_cutoff_threshold;
    logic [3:0] temp_hysteresis;
    logic       temp_auto_recover;
    logic       heat_fold_enable;
    logic [3:0] heat_fold_slope_first;
    logic [3:0] heat_fold_slope_second;
    logic [7:0] heat_fold_hold_time;
    logic [3:0] heat_fold_release_rate;
  } afts_therm_cfg_s;

endpackage : afts_pkg

// ### logic/afts_top.sv
// amplifier clock frame, speaker guard and thermal supervisor
`timescale 1ns/1ps

// Function
// - count bit clocks per frame, compare ratio
// - I2S/LJ: both channels equal bit clocks
// - TDM: no duty cycle check
// - tolerance plus one errored frames: clock irq, shutdown
// - auto: tolerance plus one good frames, recover irq, restart
// - manual: no recovery, halted until host enables
// - speaker guard on at reset, software disables
// - PWM above threshold for duration: amplifier off
// - speaker guard trip raises error irq
// - active device compares temperature with thresholds
// - irqs on warning, cutoff, foldback transitions
// - two 7-bit warnings, one 6-bit cutoff
// - falling temperature uses thresholds minus hysteresis
// - cutoff: irq, amplifier off, irqs on falling
// - manual: below high warning clears enable
// - auto: below high warning re-enables amplifier
// - above low warning: fold and irqs, slope one
// - above high warning: irq, slope two added
// - attenuation proportional, capped at -12 dB
// - gain reduction applied within one sample
// - below high warning past hold: release, irq
// - below low warning: fold ends, irqs
// - auto-restart bit selects clock monitor mode
module afts_top (
  input  wire logic                   ref_clk_i,
  input  wire logic                   arst_n_i,
  input  wire logic                   bclk_i,
  input  wire logic                   lrclk_i,
  input  wire afts_pkg::afts_fmt_e    pcm_format_i,
  input  wire logic [8:0]             bitclk_frame_ratio_i,
  input  wire logic [3:0]             frame_error_tolerance_i,
  input  wire logic                   clockmon_enable_i,
  input  wire logic                   clockmon_auto_restart_i,
  input  wire logic                   en_set_i,
  input  wire logic                   en_clr_i,
  input  wire logic                   speaker_guard_enable_i,
  input  wire logic [7:0]             pwm_level_i,
  input  wire logic [7:0]             speaker_guard_threshold_i,
  input  wire logic [7:0]             speaker_guard_duration_i,
  input  wire logic                   temp_valid_i,
  input  wire logic [6:0]             temp_i,
  input  wire afts_pkg::afts_therm_cfg_s therm_cfg_i,
  output logic                        global_enable_o,
  output logic                        sw_shutdown_o,
  output logic                        amp_disable_o,
  output logic                        fold_active_o,
  output logic [5:0]                  fold_atten_o,
  output afts_pkg::afts_irq_s         irq_o
);
  import afts_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic below_hyst(input logic [6:0] t,
                                      input logic [6:0] thr,
                                      input logic [3:0] hy);
    logic [7:0] lim;
    lim = {1'b0, thr} - {4'h0, hy};
    // threshold under hysteresis: never released
    below_hyst = !lim[7] && ({1'b0, t} < lim);
  endfunction : below_hyst

  function automatic logic [6:0] excess(input logic [6:0] t,
                                        input logic [6:0] thr);
    excess = (t > thr) ? 7'(t - thr) : 7'h00;
  endfunction : excess

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ****************************************************************
  // clock frame monitor
  // ****************************************************************
  logic       en_q, en_d;
  logic       bclk_q, lrclk_q, primed_q, primed_d, fault_q, fault_d;
  logic [8:0] seg_q, seg_d, half_q, half_d;
  logic [4:0] err_q, err_d, ok_q, ok_d;
  logic       clk_err_d, clk_rec_d, clk_en_clr;
  logic       mon_on, b_rise, lr_rise, lr_fall, frame_bad, is_tdm;
  logic [9:0] total;
  logic [4:0] tol_cnt;

  always_comb begin
    is_tdm     = (pcm_format_i == AFTS_FMT_TDM);
    mon_on     = clockmon_enable_i && en_q;
    b_rise     = bclk_i && !bclk_q;
    lr_rise    = lrclk_i && !lrclk_q;
    lr_fall    = !lrclk_i && lrclk_q;
    tol_cnt    = {1'b0, frame_error_tolerance_i} + 5'h01;
    total      = {1'b0, half_q} + {1'b0, seg_q};
    frame_bad  = (total != {1'b0, bitclk_frame_ratio_i}) ||
                 (!is_tdm && (half_q != seg_q));
    seg_d      = seg_q + {8'h00, b_rise};
    half_d     = half_q;
    primed_d   = primed_q;
    err_d      = err_q;
    ok_d       = ok_q;
    fault_d    = fault_q;
    clk_err_d  = 1'b0;
    clk_rec_d  = 1'b0;
    clk_en_clr = 1'b0;
    if (!mon_on) begin
      // halted monitor forgets partial frames, so no stale error
      seg_d    = AFTS_CNT_RST;
      half_d   = AFTS_CNT_RST;
      primed_d = 1'b0;
      err_d    = 5'h00;
      ok_d     = 5'h00;
      fault_d  = 1'b0;
    end else if (fault_q && !clockmon_auto_restart_i) begin
      fault_d    = 1'b0;
      clk_en_clr = 1'b1;
    end else if (lr_fall && !is_tdm) begin
      half_d = seg_q;
      seg_d  = {8'h00, b_rise};
    end else if (lr_rise) begin
      seg_d    = {8'h00, b_rise};
      half_d   = AFTS_CNT_RST;
      primed_d = 1'b1;
      if (primed_q && frame_bad) begin
        ok_d = 5'h00;
        if (!fault_q && (err_q + 5'h01 >= tol_cnt)) begin
          err_d     = 5'h00;
          clk_err_d = 1'b1;
          if (clockmon_auto_restart_i) begin
            fault_d = 1'b1;
          end else begin
            clk_en_clr = 1'b1;
          end
        end else if (!fault_q) begin
          err_d = err_q + 5'h01;
        end
      end else if (primed_q) begin
        err_d = 5'h00;
        if (fault_q && (ok_q + 5'h01 >= tol_cnt)) begin
          ok_d      = 5'h00;
          fault_d   = 1'b0;
          clk_rec_d = 1'b1;
        end else if (fault_q) begin
          ok_d = ok_q + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bclk_q   <= 1'b0;
      lrclk_q  <= 1'b0;
      seg_q    <= AFTS_CNT_RST;
      half_q   <= AFTS_CNT_RST;
      primed_q <= 1'b0;
      err_q    <= 5'h00;
      ok_q     <= 5'h00;
      fault_q  <= 1'b0;
    end else begin
      bclk_q   <= bclk_i;
      lrclk_q  <= lrclk_i;
      seg_q    <= seg_d;
      half_q   <= half_d;
      primed_q <= primed_d;
      err_q    <= err_d;
      ok_q     <= ok_d;
      fault_q  <= fault_d;
    end
  end

  // ****************************************************************
  // speaker guard
  // ****************************************************************
  logic [7:0] spk_cnt_q, spk_cnt_d;
  logic       spk_off_q, spk_off_d, spk_irq_d;

  always_comb begin
    spk_cnt_d = AFTS_DUR_RST;
    spk_off_d = spk_off_q && !en_set_i;
    spk_irq_d = 1'b0;
    if (speaker_guard_enable_i && !spk_off_q &&
        (pwm_level_i > speaker_guard_threshold_i)) begin
      spk_cnt_d = spk_cnt_q + 8'h01;
      if (spk_cnt_d >= speaker_guard_duration_i) begin
        spk_off_d = 1'b1;
        spk_irq_d = 1'b1;
        spk_cnt_d = AFTS_DUR_RST;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      spk_cnt_q <= AFTS_DUR_RST;
      spk_off_q <= 1'b0;
    end else begin
      spk_cnt_q <= spk_cnt_d;
      spk_off_q <= spk_off_d;
    end
  end

  // ****************************************************************
  // thermal protection and foldback
  // ****************************************************************
  logic       w1_q, w1_d, w2_q, w2_d, cut_q, cut_d, toff_q, toff_d;
  logic       fold_q, fold_d, th_en_clr;
  logic [7:0] hold_q, hold_d;
  logic [5:0] att_q, att_d, tgt;
  logic [6:0] cut7;
  logic [11:0] raw;

  always_comb begin
    cut7      = {1'b0, therm_cfg_i.temp_cutoff_threshold};
    raw       = 12'(excess(temp_i, therm_cfg_i.temp_warn_low_threshold)) *
                12'(therm_cfg_i.heat_fold_slope_first) +
                12'(excess(temp_i, therm_cfg_i.temp_warn_high_threshold)) *
                12'(therm_cfg_i.heat_fold_slope_second);
    tgt       = (raw > {6'h00, AFTS_ATT_MAX}) ? AFTS_ATT_MAX
                                              : raw[5:0];
    w1_d      = w1_q;
    w2_d      = w2_q;
    cut_d     = cut_q;
    toff_d    = toff_q;
    hold_d    = hold_q;
    att_d     = att_q;
    th_en_clr = 1'b0;
    // samples only arrive while active, so comparisons follow them
    if (temp_valid_i) begin
      w1_d  = w1_q ? !below_hyst(temp_i,
                                 therm_cfg_i.temp_warn_low_threshold,
                                 therm_cfg_i.temp_hysteresis)
                   : (temp_i > therm_cfg_i.temp_warn_low_threshold);
      cut_d = cut_q ? !below_hyst(temp_i, cut7,
                                  therm_cfg_i.temp_hysteresis)
                    : (temp_i > cut7);
      hold_d = 8'h00;
      if (!w2_q) begin
        w2_d = temp_i > therm_cfg_i.temp_warn_high_threshold;
      end else if (below_hyst(temp_i,
                              therm_cfg_i.temp_warn_high_threshold,
                              therm_cfg_i.temp_hysteresis)) begin
        hold_d = hold_q + 8'h01;
        if (hold_q >= therm_cfg_i.heat_fold_hold_time) begin
          w2_d   = 1'b0;
          hold_d = 8'h00;
        end
      end
      if (cut_d && !cut_q) begin
        toff_d = 1'b1;
      end else if (toff_q && !cut_d &&
                   below_hyst(temp_i,
                              therm_cfg_i.temp_warn_high_threshold,
                              therm_cfg_i.temp_hysteresis)) begin
        toff_d    = 1'b0;
        th_en_clr = !therm_cfg_i.temp_auto_recover;
      end
      if (!therm_cfg_i.heat_fold_enable || !w1_d) begin
        att_d = AFTS_ATT_RST;
      end else if (tgt > att_q) begin
        att_d = tgt;
      end else if (!w2_d) begin
        // release only while the high warning is off, never below the live target
        att_d = (att_q > tgt + 6'(therm_cfg_i.heat_fold_release_rate))
                ? att_q - 6'(therm_cfg_i.heat_fold_release_rate)
                : tgt;
      end
    end
    fold_d = therm_cfg_i.heat_fold_enable && w1_d;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      w1_q   <= 1'b0;
      w2_q   <= 1'b0;
      cut_q  <= 1'b0;
      toff_q <= 1'b0;
      fold_q <= 1'b0;
      hold_q <= AFTS_DUR_RST;
      att_q  <= AFTS_ATT_RST;
    end else begin
      w1_q   <= w1_d;
      w2_q   <= w2_d;
      cut_q  <= cut_d;
      toff_q <= toff_d;
      fold_q <= fold_d;
      hold_q <= hold_d;
      att_q  <= att_d;
    end
  end

  // ****************************************************************
  // enable, interrupts and outputs
  // ****************************************************************
  afts_irq_s irq_d;

  always_comb begin
    en_d = en_q;
    if (en_clr_i || clk_en_clr || th_en_clr) begin
      en_d = 1'b0;
    end
    // host write of one wins over a same-cycle hardware clear
    if (en_set_i) begin
      en_d = 1'b1;
    end
    irq_d                         = '0;
    irq_d.clk_err                 = clk_err_d;
    irq_d.clk_recover             = clk_rec_d;
    irq_d.speaker_guard_error_irq = spk_irq_d;
    irq_d.cutoff_begin            = cut_d && !cut_q;
    irq_d.cutoff_end              = !cut_d && cut_q;
    irq_d.warn_low_begin_irq      = w1_d && !w1_q;
    irq_d.warn_low_end_irq        = !w1_d && w1_q;
    irq_d.warn_high_begin_irq     = w2_d && !w2_q;
    irq_d.warn_high_end_irq       = !w2_d && w2_q;
    irq_d.heat_fold_begin_irq     = fold_d && !fold_q;
    irq_d.heat_fold_end_irq       = !fold_d && fold_q;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      en_q            <= AFTS_EN_RST;
      global_enable_o <= AFTS_EN_RST;
      sw_shutdown_o   <= 1'b1;
      amp_disable_o   <= 1'b0;
      fold_active_o   <= 1'b0;
      fold_atten_o    <= AFTS_ATT_RST;
      irq_o           <= '0;
    end else begin
      en_q            <= en_d;
      global_enable_o <= en_d;
      sw_shutdown_o   <= !en_d || fault_d;
      amp_disable_o   <= spk_off_d || toff_d;
      fold_active_o   <= fold_d;
      fold_atten_o    <= att_d;
      irq_o           <= irq_d;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n);

  AST_SPK_IRQ: assert property (
    $rose(spk_off_q) |-> irq_o.speaker_guard_error_irq)
    else $error("speaker trip without irq");
  AST_SPK_OFF: assert property (
    spk_off_q |-> amp_disable_o)
    else $error("speaker trip left amplifier on");
  AST_SPK_IDLE: assert property (
    !speaker_guard_enable_i |=> spk_cnt_q == 8'h00)
    else $error("disabled speaker guard still counting");
  AST_CLK_ERR: assert property (
    irq_o.clk_err |-> sw_shutdown_o)
    else $error("clock error without shutdown");
  AST_NO_MAN_REC: assert property (
    irq_o.clk_recover |-> $past(clockmon_auto_restart_i))
    else $error("recovery irq in manual mode");
  AST_REC_RUN: assert property (
    irq_o.clk_recover && global_enable_o |-> !sw_shutdown_o)
    else $error("recovery left shutdown");
  AST_ATT_CAP: assert property (
    fold_atten_o <= AFTS_ATT_MAX)
    else $error("attenuation above cap");
  AST_ATTACK: assert property (
    temp_valid_i && fold_d && tgt > att_q |=> fold_atten_o == $past(tgt))
    else $error("attack slower than one sample");
  AST_CUT_OFF: assert property (
    irq_o.cutoff_begin |-> amp_disable_o ##1 amp_disable_o)
    else $error("cutoff left amplifier on");

endmodule : afts_top

// ### tb/afts_pcm_host.sv
// host side model making the bit and frame clocks
`timescale 1ns/1ps
module afts_pcm_host (
  input  wire logic       ref_clk_i,
  input  wire logic       run_i,
  input  wire logic [8:0] first_half_i,
  input  wire logic [8:0] second_half_i,
  output logic            bclk_o,
  output logic            lrclk_o
);
  // ****************************************************************
  // frame generator
  // ****************************************************************
  // clocks stand still between frames while run_i is low
  task automatic bit_period;
    repeat (2) @(negedge ref_clk_i);
    bclk_o = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    bclk_o = 1'b0;
  endtask : bit_period

  initial begin
    bclk_o  = 1'b0;
    lrclk_o = 1'b1;
    forever begin
      @(negedge ref_clk_i);
      if (run_i) begin
        lrclk_o = 1'b0;
        for (int i = 0; i < first_half_i; i++) bit_period();
        lrclk_o = 1'b1;
        for (int i = 0; i < second_half_i; i++) bit_period();
      end
    end
  end
endmodule : afts_pcm_host

// ### tb/testbench.sv
// self-checking testbench of the fault and thermal supervisor
`timescale 1ns/1ps
module testbench;
  import afts_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  localparam int IQ_CERR = 10, IQ_CREC = 9, IQ_SPK = 8, IQ_CUTB = 7;
  localparam int IQ_CUTE = 6, IQ_WLB = 5, IQ_WLE = 4, IQ_WHB = 3;
  localparam int IQ_WHE = 2, IQ_FBB = 1, IQ_FBE = 0;
  logic            ref_clk_i, arst_n_i, bclk_i, lrclk_i, pcm_run;
  logic [8:0]      half_a, half_b, bitclk_frame_ratio_i;
  afts_fmt_e       pcm_format_i;
  logic [3:0]      frame_error_tolerance_i;
  logic            clockmon_enable_i, clockmon_auto_restart_i;
  logic            en_set_i, en_clr_i, speaker_guard_enable_i;
  logic [7:0]      pwm_level_i, speaker_guard_threshold_i;
  logic [7:0]      speaker_guard_duration_i;
  logic            temp_valid_i;
  logic [6:0]      temp_i;
  afts_therm_cfg_s therm_cfg_i;
  logic            global_enable_o, sw_shutdown_o, amp_disable_o;
  logic            fold_active_o;
  logic [5:0]      fold_atten_o;
  afts_irq_s       irq_o;
  int              miscompares, cmp_count, irq_cnt[11];

  afts_pcm_host host (.ref_clk_i(ref_clk_i), .run_i(pcm_run),
    .first_half_i(half_a), .second_half_i(half_b),
    .bclk_o(bclk_i), .lrclk_o(lrclk_i));

  afts_top dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .bclk_i(bclk_i), .lrclk_i(lrclk_i), .pcm_format_i(pcm_format_i),
    .bitclk_frame_ratio_i(bitclk_frame_ratio_i),
    .frame_error_tolerance_i(frame_error_tolerance_i),
    .clockmon_enable_i(clockmon_enable_i),
    .clockmon_auto_restart_i(clockmon_auto_restart_i),
    .en_set_i(en_set_i), .en_clr_i(en_clr_i),
    .speaker_guard_enable_i(speaker_guard_enable_i),
    .pwm_level_i(pwm_level_i),
    .speaker_guard_threshold_i(speaker_guard_threshold_i),
    .speaker_guard_duration_i(speaker_guard_duration_i),
    .temp_valid_i(temp_valid_i), .temp_i(temp_i),
    .therm_cfg_i(therm_cfg_i), .global_enable_o(global_enable_o),
    .sw_shutdown_o(sw_shutdown_o), .amp_disable_o(amp_disable_o),
    .fold_active_o(fold_active_o), .fold_atten_o(fold_atten_o),
    .irq_o(irq_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // irq pulses stand one cycle, so one falling edge sees each
  always @(negedge ref_clk_i) begin
    for (int i = 0; i < 11; i++) irq_cnt[i] += (irq_o[i] === 1'b1);
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic fail(input string msg);
    miscompares++;
    $display("Error at %0t: %s", $time, msg);
  endtask : fail

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) fail($sformatf("bit %b expected %b", got, exp));
  endtask : chk_bit

  task automatic chk_att(input logic [5:0] exp);
    cmp_count++;
    if (fold_atten_o !== exp) fail($sformatf("atten %h expected %h",
                                              fold_atten_o, exp));
  endtask : chk_att

  task automatic chk_cnt(input int idx, input int exp);
    cmp_count++;
    if (irq_cnt[idx] != exp) fail($sformatf("irq %0d count %0d not %0d",
                                            idx, irq_cnt[idx], exp));
  endtask : chk_cnt

  task automatic clr_cnt;
    @(posedge ref_clk_i);
    for (int i = 0; i < 11; i++) irq_cnt[i] = 0;
  endtask : clr_cnt

  task automatic wait_irq(input int idx, input int bound);
    int base;
    base = irq_cnt[idx];
    cmp_count++;
    for (int n = 0; n < bound && irq_cnt[idx] == base; n++)
      @(negedge ref_clk_i);
    if (irq_cnt[idx] == base) begin
      fail($sformatf("irq %0d never came", idx));
      final_report();
    end
    repeat (2) @(negedge ref_clk_i);
  endtask : wait_irq

  task automatic en_pulse(input logic set);
    @(negedge ref_clk_i);
    if (set) en_set_i = 1'b1;
    else en_clr_i = 1'b1;
    @(negedge ref_clk_i);
    en_set_i = 1'b0;
    en_clr_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask : en_pulse

  task automatic sample(input logic [6:0] t, input int times);
    repeat (times) begin
      @(negedge ref_clk_i);
      temp_i       = t;
      temp_valid_i = 1'b1;
      @(negedge ref_clk_i);
      temp_valid_i = 1'b0;
      repeat (4) @(negedge ref_clk_i);
    end
  endtask : sample

  task automatic pwm_for(input int cycles);
    @(negedge ref_clk_i);
    pwm_level_i = 8'h90;
    repeat (cycles) @(negedge ref_clk_i);
    pwm_level_i = 8'h10;
    repeat (4) @(negedge ref_clk_i);
  endtask : pwm_for

  task automatic frames(input logic [8:0] a, input logic [8:0] b);
    half_a = a;
    half_b = b;
  endtask : frames

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    arst_n_i = 1'b0;  pcm_run = 1'b0;  frames(9'h020, 9'h020);
    bitclk_frame_ratio_i = 9'h040;  pcm_format_i = AFTS_FMT_I2S;
    frame_error_tolerance_i = 4'h0;  clockmon_enable_i = 1'b0;
    clockmon_auto_restart_i = 1'b1;  en_set_i = 1'b0;  en_clr_i = 1'b0;
    speaker_guard_enable_i = 1'b1;  pwm_level_i = 8'h10;
    speaker_guard_threshold_i = 8'h80;  speaker_guard_duration_i = 8'h10;
    temp_valid_i = 1'b0;  temp_i = 7'h14;
    // warn 40/50, cutoff 60, hyst 4, auto, fold, slopes 1/2, hold 2
    therm_cfg_i = '{7'h28, 7'h32, 6'h3C, 4'h4, 1'b1, 1'b1,
                    4'h1, 4'h2, 8'h02, 4'h4};
    repeat (20) @(negedge ref_clk_i);
    arst_n_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    chk_bit(global_enable_o, 1'b0);
    chk_bit(sw_shutdown_o, 1'b1);
    chk_bit(amp_disable_o, 1'b0);
    en_pulse(1'b1);
    chk_bit(sw_shutdown_o, 1'b0);
    $display("test reset done");
    // clock monitor, automatic restart
    clr_cnt();  pcm_run = 1'b1;  clockmon_enable_i = 1'b1;
    repeat (900) @(negedge ref_clk_i);
    chk_cnt(IQ_CERR, 0);
    frames(9'h020, 9'h01F);
    wait_irq(IQ_CERR, 1500);
    chk_bit(sw_shutdown_o, 1'b1);
    chk_bit(global_enable_o, 1'b1);
    frames(9'h020, 9'h020);
    wait_irq(IQ_CREC, 1500);
    chk_bit(sw_shutdown_o, 1'b0);
    frames(9'h01E, 9'h022);
    wait_irq(IQ_CERR, 1500);
    pcm_format_i = AFTS_FMT_TDM;
    wait_irq(IQ_CREC, 1500);
    $display("test clock auto done");
    // clock monitor, manual mode, left-justified duty error
    pcm_format_i = AFTS_FMT_LJ;  clockmon_auto_restart_i = 1'b0;
    wait_irq(IQ_CERR, 1500);
    chk_bit(global_enable_o, 1'b0);
    chk_bit(sw_shutdown_o, 1'b1);
    clr_cnt();  frames(9'h020, 9'h020);
    repeat (1200) @(negedge ref_clk_i);
    chk_cnt(IQ_CREC, 0);
    chk_bit(sw_shutdown_o, 1'b1);
    en_pulse(1'b1);
    chk_bit(sw_shutdown_o, 1'b0);
    clockmon_enable_i = 1'b0;  pcm_run = 1'b0;
    $display("test clock manual done");
    // speaker guard
    clr_cnt();  pwm_for(8);
    chk_cnt(IQ_SPK, 0);
    pwm_for(40);
    chk_cnt(IQ_SPK, 1);
    chk_bit(amp_disable_o, 1'b1);
    en_pulse(1'b1);
    chk_bit(amp_disable_o, 1'b0);
    speaker_guard_enable_i = 1'b0;
    pwm_for(40);
    chk_cnt(IQ_SPK, 1);
    chk_bit(amp_disable_o, 1'b0);
    speaker_guard_enable_i = 1'b1;
    $display("test speaker guard done");
    // thermal foldback
    clr_cnt();  sample(7'h2D, 1);
    chk_cnt(IQ_FBB, 1);
    chk_cnt(IQ_WLB, 1);
    chk_bit(fold_active_o, 1'b1);
    chk_att(6'h05);
    sample(7'h34, 1);
    chk_cnt(IQ_WHB, 1);
    chk_att(6'h10);
    sample(7'h38, 1);
    chk_att(AFTS_ATT_MAX);
    sample(7'h30, 1);
    sample(7'h2C, 1);
    chk_cnt(IQ_WHE, 0);
    sample(7'h2C, 4);
    chk_cnt(IQ_WHE, 1);
    chk_cnt(IQ_WLE, 0);
    sample(7'h26, 1);
    chk_bit(fold_active_o, 1'b1);
    sample(7'h23, 1);
    chk_cnt(IQ_FBE, 1);
    chk_cnt(IQ_WLE, 1);
    chk_bit(fold_active_o, 1'b0);
    chk_att(AFTS_ATT_RST);
    therm_cfg_i.heat_fold_enable = 1'b0;
    sample(7'h2D, 1);
    chk_bit(fold_active_o, 1'b0);
    chk_att(AFTS_ATT_RST);
    therm_cfg_i.heat_fold_enable = 1'b1;
    sample(7'h14, 1);
    $display("test foldback done");
    // thermal cutoff, automatic then manual recovery
    clr_cnt();  sample(7'h3D, 1);
    chk_cnt(IQ_CUTB, 1);
    chk_bit(amp_disable_o, 1'b1);
    sample(7'h39, 1);
    chk_cnt(IQ_CUTE, 0);
    sample(7'h37, 1);
    chk_cnt(IQ_CUTE, 1);
    chk_bit(amp_disable_o, 1'b1);
    sample(7'h2D, 5);
    chk_bit(amp_disable_o, 1'b0);
    chk_bit(global_enable_o, 1'b1);
    sample(7'h14, 2);
    therm_cfg_i.temp_auto_recover = 1'b0;
    sample(7'h3D, 1);
    chk_bit(amp_disable_o, 1'b1);
    sample(7'h14, 6);
    chk_bit(global_enable_o, 1'b0);
    chk_bit(sw_shutdown_o, 1'b1);
    en_pulse(1'b1);
    chk_bit(global_enable_o, 1'b1);
    en_pulse(1'b0);
    chk_bit(sw_shutdown_o, 1'b1);
    $display("test cutoff done");
    final_report();
  end
endmodule : testbench
